// >>> ctmb_bank.sv
// Implementation choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
// How it works
// - on-delay: high after input held interval
// - off-delay: low after input low interval
// - function codes 1..4 select mode
// - pulse: rising edge gives interval-long high
// - interval zero to 6500 s, default zero
// - inactive by default, contributes nothing
// - source codes: unused, constants, inputs, blocks
// - output readable, 0 off 1 on
// - six identical modules with listed defaults
// - active module with unused source alarms
module ctmb_bank
  import ctmb_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // time base: one pulse per second from the system timer, same domain
  input wire logic secTick,
  // signal network: bit n is source code n; internal, same domain
  input wire logic [STAT_W-1:0] statusIn,
  // digital input pins, asynchronous
  input wire logic [4:0] digIn,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // results
  output logic [MOD_COUNT-1:0] timerOut,
  output logic config_incomplete_alarm,
  output logic irq
);
  // word addresses; per module: cfg at 2*i, interval at 2*i+1
  localparam logic [4:0] ADDR_LAST_CFG = 5'h0b;
  localparam logic [4:0] ADDR_OUT = 5'h0c;
  localparam logic [4:0] ADDR_IRQ_STAT = 5'h0d;
  localparam logic [4:0] ADDR_IRQ_CLR = 5'h0e;
  localparam logic [4:0] ADDR_IRQ_EN = 5'h0f;
  localparam int IRQ_W = MOD_COUNT + 1;
  localparam int ACT_BIT = 8;
  localparam int FUNC_LSB = 16;
  localparam logic [31:0] UNMAPPED = 32'h00000000;

  typedef struct packed {
    ctmb_cfg_t [MOD_COUNT-1:0] cfg;
    ctmb_chan_t [MOD_COUNT-1:0] chan;
    logic [1:0][4:0] digSync;
    logic alarm;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqEn;
    logic irq;
    logic [31:0] rdata;
    logic ack;
  } ctmb_state_t;

  ctmb_state_t st_reg, st_next;

  // digital inputs take the place of source codes 63..67 after sync
  function automatic logic pick(input logic [SEL_W-1:0] src, input logic [STAT_W-1:0] net,
                                input logic [4:0] di);
    logic v;
    v = 1'b0;
    if (src == SEL_UNUSED || src == SEL_LOW || src > SEL_LAST) begin
      v = 1'b0;
    end else if (src == SEL_HIGH) begin
      v = 1'b1;
    end else if (src >= SEL_DI_FIRST && src <= SEL_DI_LAST) begin
      v = di[3'(src - SEL_DI_FIRST)];
    end else begin
      v = net[src];
    end
    return v;
  endfunction

  // an interval write beyond the range saturates instead of wrapping
  function automatic logic [TIME_W-1:0] clampTime(input logic [15:0] t);
    logic [TIME_W-1:0] r;
    r = (t > 16'(TIME_MAX_S)) ? TIME_MAX_S : t[TIME_W-1:0];
    return r;
  endfunction

  // register groups behind a word address; the read and write paths share one decode
  typedef enum logic [6:0] {
    RK_NONE = 7'h01,
    RK_CFG = 7'h02,
    RK_TIME = 7'h04,
    RK_OUT = 7'h08,
    RK_STAT = 7'h10,
    RK_CLR = 7'h20,
    RK_EN = 7'h40
  } ctmb_rkind_t;

  function automatic ctmb_rkind_t decodeAddr(
    input logic [4:0] a
  );
    ctmb_rkind_t k;
    k = RK_NONE;
    if (a <= ADDR_LAST_CFG) begin
      k = a[0] ? RK_TIME : RK_CFG;
    end else if (a == ADDR_OUT) begin
      k = RK_OUT;
    end else if (a == ADDR_IRQ_STAT) begin
      k = RK_STAT;
    end else if (a == ADDR_IRQ_CLR) begin
      k = RK_CLR;
    end else if (a == ADDR_IRQ_EN) begin
      k = RK_EN;
    end
    return k;
  endfunction

  // one module's settings in the layout that software writes
  function automatic logic [31:0] cfgWord(
    input ctmb_cfg_t c
  );
    logic [31:0] w;
    w = UNMAPPED;
    w[ACT_BIT] = c.active;
    w[SEL_W-1:0] = c.source;
    w[FUNC_LSB +: FUNC_W] = c.func;
    return w;
  endfunction

  // byte lanes let software change one field without disturbing the others
  function automatic ctmb_cfg_t mergeCfg(
    input ctmb_cfg_t c,
    input logic [31:0] d,
    input logic [3:0] be
  );
    ctmb_cfg_t r;
    r = c;
    if (be[0]) begin
      r.source = d[SEL_W-1:0];
    end
    if (be[1]) begin
      r.active = d[ACT_BIT];
    end
    if (be[2]) begin
      r.func = d[FUNC_LSB +: FUNC_W];
    end
    return r;
  endfunction

  // counts one second per tick and holds at the top of the range instead of wrapping
  function automatic logic [TIME_W-1:0] advance(
    input logic [TIME_W-1:0] e,
    input logic tick
  );
    logic [TIME_W-1:0] r;
    r = e;
    if (tick && e != TIME_MAX_S) begin
      r = e + 1'b1;
    end
    return r;
  endfunction

  // next state of one active module from its settings, its selected input and the time base
  function automatic ctmb_chan_t stepChan(
    input ctmb_cfg_t k,
    input ctmb_chan_t c,
    input logic inNow,
    input logic tick
  );
    ctmb_chan_t n;
    logic reached;
    n = c;
    reached = (c.elapsed >= k.interval);
    n.inPrev = inNow;
    case (k.func)
      FN_ON_DELAY: begin
        if (!inNow) begin
          n.outVal = 1'b0;
          n.elapsed = '0;
        end else if (reached) begin
          n.outVal = 1'b1;
        end else begin
          n.elapsed = advance(c.elapsed, tick);
        end
      end
      FN_OFF_DELAY: begin
        if (inNow) begin
          n.outVal = 1'b1;
          n.elapsed = '0;
        end else if (reached) begin
          n.outVal = 1'b0;
        end else begin
          n.elapsed = advance(c.elapsed, tick);
        end
      end
      FN_ON_OFF: begin
        // timing runs while input differs from output; a return restarts it
        if (inNow == c.outVal) begin
          n.elapsed = '0;
        end else if (reached) begin
          n.outVal = inNow;
          n.elapsed = '0;
        end else begin
          n.elapsed = advance(c.elapsed, tick);
        end
      end
      FN_PULSE: begin
        // retrigger during a pulse is ignored; pulse length is fixed
        if (c.outVal) begin
          if (reached) begin
            n.outVal = 1'b0;
          end else begin
            n.elapsed = advance(c.elapsed, tick);
          end
        end else if (inNow && !c.inPrev && k.interval != TIME_RST_S) begin
          n.outVal = 1'b1;
          n.elapsed = '0;
        end
      end
      default: begin
        n.outVal = 1'b0;
        n.elapsed = '0;
      end
    endcase
    return n;
  endfunction

  // sticky status: a new event wins over a clear in the same cycle
  function automatic logic [IRQ_W-1:0] stickyNext(
    input logic [IRQ_W-1:0] s,
    input logic [IRQ_W-1:0] clr,
    input logic [IRQ_W-1:0] ev
  );
    logic [IRQ_W-1:0] r;
    r = (s & ~clr) | ev;
    return r;
  endfunction

  logic [MOD_COUNT-1:0] selIn;
  logic [STAT_W-1:0] net;

  // other timers' outputs feed back through the network; use our own registered values
  always_comb begin
    net = statusIn;
    for (int k = 0; k < MOD_COUNT; k++) begin
      net[SEL_T_FIRST + k] = st_reg.chan[k].outVal;
    end
    for (int k = 0; k < MOD_COUNT; k++) begin
      selIn[k] = pick(st_reg.cfg[k].source, net, st_reg.digSync[1]);
    end
  end

  logic hit;
  logic [3:0] wIdx;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] clrMask;
  ctmb_rkind_t kind;

  assign kind = decodeAddr(address);

  always_comb begin
    logic inNow;
    logic anyUnused;
    inNow = 1'b0;
    anyUnused = 1'b0;
    hit = 1'b0;
    clrMask = '0;
    wIdx = 4'h0;
    events = '0;
    st_next = st_reg;
    st_next.digSync[0] = digIn;
    st_next.digSync[1] = st_reg.digSync[0];

    for (int i = 0; i < MOD_COUNT; i++) begin
      inNow = selIn[i];
      if (!st_reg.cfg[i].active) begin
        // inactive modules hold everything cleared
        st_next.chan[i] = '0;
      end else begin
        st_next.chan[i] = stepChan(st_reg.cfg[i], st_reg.chan[i], inNow, secTick);
      end
      if (st_reg.cfg[i].active && st_reg.cfg[i].source == SEL_UNUSED) begin
        anyUnused = 1'b1;
      end
      events[i] = st_next.chan[i].outVal & ~st_reg.chan[i].outVal;
    end
    st_next.alarm = anyUnused;
    events[MOD_COUNT] = anyUnused & ~st_reg.alarm;

    // single-cycle bus: waitrequest low on the second cycle of a request
    st_next.ack = (read | write) & ~st_reg.ack;
    st_next.rdata = UNMAPPED;
    if (read && !st_reg.ack) begin
      wIdx = 4'(address[4:1]);
      if (kind == RK_CFG) begin
        st_next.rdata = cfgWord(st_reg.cfg[wIdx]);
      end else if (kind == RK_TIME) begin
        st_next.rdata[TIME_W-1:0] = st_reg.cfg[wIdx].interval;
      end else if (kind == RK_OUT) begin
        st_next.rdata[MOD_COUNT-1:0] = timerOut;
        st_next.rdata[MOD_COUNT] = st_reg.alarm;
      end else if (kind == RK_STAT) begin
        st_next.rdata[IRQ_W-1:0] = st_reg.irqStat;
      end else if (kind == RK_EN) begin
        st_next.rdata[IRQ_W-1:0] = st_reg.irqEn;
      end
    end

    // a write lands at the edge where the master sees waitrequest low, not one earlier
    hit = write && st_reg.ack;
    if (hit) begin
      wIdx = 4'(address[4:1]);
      if (kind == RK_CFG) begin
        st_next.cfg[wIdx] = mergeCfg(st_reg.cfg[wIdx], writedata, byteenable);
      end else if (kind == RK_TIME) begin
        if (byteenable[1:0] == 2'b11) begin
          st_next.cfg[wIdx].interval = clampTime(writedata[15:0]);
        end
      end else if (kind == RK_CLR) begin
        if (byteenable[0]) begin
          clrMask = writedata[IRQ_W-1:0];
        end
      end else if (kind == RK_EN) begin
        if (byteenable[0]) begin
          st_next.irqEn = writedata[IRQ_W-1:0];
        end
      end
    end
    st_next.irqStat = stickyNext(st_reg.irqStat, clrMask, events);
    st_next.irq = |(st_next.irqStat & st_next.irqEn);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
      for (int i = 0; i < MOD_COUNT; i++) begin
        st_reg.cfg[i].func <= FN_ON_DELAY;
        st_reg.cfg[i].interval <= TIME_RST_S;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    for (int i = 0; i < MOD_COUNT; i++) begin
      timerOut[i] = st_reg.chan[i].outVal;
    end
  end
  assign readdata = st_reg.rdata;
  assign waitrequest = ~st_reg.ack;
  assign config_incomplete_alarm = st_reg.alarm;
  assign irq = st_reg.irq;
endmodule

// >>> ctmb_bank_sva.sv
`timescale 1ns/1ps
module ctmb_bank_sva
  import ctmb_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // bus
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // results
  input wire logic [MOD_COUNT-1:0] timerOut,
  input wire logic config_incomplete_alarm,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic wrAck;
  logic rdAck;
  logic cfgSeen_reg;
  assign wrAck = write && !waitrequest;
  assign rdAck = read && !waitrequest;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) cfgSeen_reg <= 1'b0;
    else if (wrAck) cfgSeen_reg <= 1'b1;
  end
  property p_answer; $rose(read || write) |=> !waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("no answer one cycle after request");
  property p_ackOne; !waitrequest |=> waitrequest; endproperty
  a_ackOne: assert property (p_ackOne) else $error("answer held too long");
  property p_idle; !(read || write) |-> waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_rdZero; waitrequest |-> readdata == 32'h0; endproperty
  a_rdZero: assert property (p_rdZero) else $error("read data outside answer");
  property p_unmapped; rdAck && address[4] |-> readdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_outRead;
    rdAck && address == 5'h0c |-> readdata[6:0] == {config_incomplete_alarm, timerOut}
      || readdata[6:0] == {$past(config_incomplete_alarm), $past(timerOut)};
  endproperty
  a_outRead: assert property (p_outRead) else $error("output read mismatch");
  property p_quiet; !cfgSeen_reg |-> timerOut == '0 && !config_incomplete_alarm && !irq; endproperty
  a_quiet: assert property (p_quiet) else $error("activity before configuration");
  property p_alarmCause; $changed(config_incomplete_alarm) |-> $past(wrAck) || $past(wrAck, 2); endproperty
  a_alarmCause: assert property (p_alarmCause) else $error("alarm moved without config write");
endmodule
bind ctmb_bank ctmb_bank_sva ctmb_bank_sva_inst (.ref_clk, .rstn, .address, .read, .write, .readdata,
  .waitrequest, .timerOut, .config_incomplete_alarm, .irq);

// >>> ctmb_net_model.sv
`timescale 1ns/1ps
module ctmb_net_model
  import ctmb_pkg::*;
#(parameter int TICK_CYC = 50)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // network side
  input wire logic sig,
  output logic secTick,
  output logic [STAT_W-1:0] statusIn
);
  logic [7:0] cnt;
  // short tick period keeps the interval tests quick
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 8'h00;
      secTick <= 1'b0;
    end else begin
      secTick <= (cnt == 8'(TICK_CYC - 1));
      cnt <= (cnt == 8'(TICK_CYC - 1)) ? 8'h00 : cnt + 8'h01;
    end
  end
  assign statusIn = {{(STAT_W-4){1'b0}}, sig, 3'h0};
endmodule

// >>> ctmb_pkg.sv
package ctmb_pkg;
  localparam int MOD_COUNT = 6;
  localparam int SEL_W = 7;
  localparam int FUNC_W = 3;
  localparam int TIME_W = 13;
  localparam int STAT_W = 118;
  localparam int TICKS_W = 30;

  localparam logic [SEL_W-1:0] SEL_UNUSED = 7'h00;
  localparam logic [SEL_W-1:0] SEL_LOW = 7'h01;
  localparam logic [SEL_W-1:0] SEL_HIGH = 7'h02;
  localparam logic [SEL_W-1:0] SEL_DI_FIRST = 7'h3f;
  localparam logic [SEL_W-1:0] SEL_DI_LAST = 7'h43;
  localparam logic [SEL_W-1:0] SEL_T_FIRST = 7'h62;
  localparam logic [SEL_W-1:0] SEL_LAST = 7'h75;

  localparam logic [FUNC_W-1:0] FN_ON_DELAY = 3'h1;
  localparam logic [FUNC_W-1:0] FN_OFF_DELAY = 3'h2;
  localparam logic [FUNC_W-1:0] FN_ON_OFF = 3'h3;
  localparam logic [FUNC_W-1:0] FN_PULSE = 3'h4;

  localparam logic [TIME_W-1:0] TIME_MAX_S = 13'h1964;
  localparam logic [TIME_W-1:0] TIME_RST_S = 13'h0000;

  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_S_NUM = 1;

  typedef struct packed {
    logic active;
    logic [SEL_W-1:0] source;
    logic [FUNC_W-1:0] func;
    logic [TIME_W-1:0] interval;
  } ctmb_cfg_t;

  typedef struct packed {
    logic inPrev;
    logic outVal;
    logic [TIME_W-1:0] elapsed;
  } ctmb_chan_t;
endpackage

// >>> tb_configurable_time_module_bank.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin nErrors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_configurable_time_module_bank
  import ctmb_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic sig = 1'b0;
  logic secTick;
  logic [STAT_W-1:0] statusIn;
  logic [4:0] digIn = 5'h01;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest;
  logic [MOD_COUNT-1:0] timerOut;
  logic config_incomplete_alarm;
  logic irq;
  logic [31:0] rdv;
  int nErrors = 0;
  int testsRun = 0;
  int cycles = 0;
  initial forever #5 ref_clk = ~ref_clk;
  ctmb_net_model ctmb_net_model_inst (.ref_clk, .rstn, .sig, .secTick, .statusIn);
  ctmb_bank ctmb_bank_inst (.ref_clk, .rstn, .secTick, .statusIn, .digIn, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .timerOut, .config_incomplete_alarm, .irq);
  task automatic endOfTest;
    if (nErrors == 0 && testsRun > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      nErrors++;
      endOfTest();
    end
  end
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    address <= a;
    read <= 1'b1;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask
  task automatic tk(input int n);
    repeat (n) begin
      do @(posedge ref_clk); while (secTick !== 1'b1);
    end
    repeat (3) @(posedge ref_clk);
  endtask
  function automatic logic [31:0] cfg(input logic [SEL_W-1:0] s, input logic [FUNC_W-1:0] f);
    return {13'h0, f, 7'h0, 1'b1, 1'b0, s};
  endfunction
  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 0; i < MOD_COUNT; i++) begin
      rd(5'(2 * i), rdv);
      `CHK("cfg default", 32'h0001_0000, rdv)
      rd(5'(2 * i + 1), rdv);
      `CHK("interval default", 32'h0, rdv)
    end
    rd(5'h10, rdv);
    `CHK("unmapped", 32'h0, rdv)
    wr(5'h00, 32'h0001_0100);
    repeat (3) @(posedge ref_clk);
    `CHK("alarm set", 1'b1, config_incomplete_alarm)
    `CHK("irq masked", 1'b0, irq)
    wr(5'h0f, 32'h40);
    repeat (2) @(posedge ref_clk);
    `CHK("irq on", 1'b1, irq)
    wr(5'h0e, 32'h40);
    wr(5'h0f, 32'h0);
    rd(5'h0d, rdv);
    `CHK("status cleared", 32'h0, rdv)
    // modules 0..3 take one source with codes 1..4 so all modes see the same stimulus
    for (int i = 0; i < 4; i++) begin
      wr(5'(2 * i + 1), 32'h2);
      wr(5'(2 * i), cfg(7'h03, 3'(i + 1)));
    end
    wr(5'h09, 32'h0000_ffff);
    rd(5'h09, rdv);
    `CHK("interval clamp", {19'h0, TIME_MAX_S}, rdv)
    wr(5'h08, cfg(SEL_LOW, FN_OFF_DELAY));
    wr(5'h0a, cfg(SEL_DI_FIRST, FN_ON_DELAY));
    repeat (8) @(posedge ref_clk);
    `CHK("alarm gone", 1'b0, config_incomplete_alarm)
    `CHK("idle outs", 6'h20, timerOut)
    tk(1);
    sig <= 1'b1;
    repeat (5) @(posedge ref_clk);
    `CHK("rise", 6'h2a, timerOut)
    tk(1);
    `CHK("rise t1", 6'h2a, timerOut)
    tk(2);
    `CHK("rise t3", 6'h27, timerOut)
    rd(5'h0c, rdv);
    `CHK("out reg", 32'h27, rdv)
    sig <= 1'b0;
    digIn <= 5'h00;
    repeat (8) @(posedge ref_clk);
    `CHK("fall", 6'h06, timerOut)
    tk(1);
    `CHK("fall t1", 6'h06, timerOut)
    tk(2);
    `CHK("fall t3", 6'h00, timerOut)
    rd(5'h0d, rdv);
    `CHK("rise events", 32'h2f, rdv)
    `CHK("irq off", 1'b0, irq)
    sig <= 1'b1;
    tk(1);
    sig <= 1'b0;
    repeat (3) @(posedge ref_clk);
    sig <= 1'b1;
    tk(1);
    `CHK("restart", 1'b0, timerOut[0])
    endOfTest();
  end
endmodule
